// file: adcsc_pkg.sv
// Purpose: Shared constants and types of the converter status and
//          compare-enable block.
// Assumes: One clock, registers on an AHB-Lite slave, 32-bit words.
// Notes:   Register indices are word indices; byte address is four
//          times the index.
// Behaviour
// R1 - Sequence end sets done flag, every scan pass.
// R2 - Done flag cleared by W1, start write, fast-read.
// R3 - Edge trigger during running sequence sets trigger overrun.
// R4 - Overruns cleared by W1, control, compare, start writes.
// R5 - Result write with conversion flag set flags overrun.
// R6 - Counter bits read-only; flag bits always writable.
// R7 - Counter indexes result register of current conversion.
// R8 - Non-FIFO: counter zeroed at sequence start and end.
// R9 - FIFO: counter kept across sequences; counter wraps.
// R10 - Compare-enable write aborts running sequence; always RW.
// R11 - Ten compare enables, one per conversion position.
// R12 - Software loads compare value, then direction bit.
// R13 - Compare success reported through conversion done flag.
// R14 - Compare position keeps stored value, drops result.
// R15 - Direction 1 means higher; 0 means lower or equal.
// R16 - Reset zeroes flags, counter and compare enables.
package adcsc_pkg;

	// Widths of the datapath.
	localparam int NPOS = 10;
	localparam int RESW = 10;
	localparam int CCW = 4;
	localparam int IDXW = 8;
	localparam int NIRQ = 3;
	localparam int NCFG = 5;

	// Register word indices.
	localparam logic [IDXW-1:0] IDX_CTL4 = 8'h04;
	localparam logic [IDXW-1:0] IDX_START = 8'h05;
	localparam logic [IDXW-1:0] IDX_STAT = 8'h06;
	localparam logic [IDXW-1:0] IDX_CMPE = 8'h08;
	localparam logic [IDXW-1:0] IDX_COMPARE_DIRECTION_BIT = 8'h0E;
	localparam logic [IDXW-1:0] IDX_ISTAT = 8'h10;
	localparam logic [IDXW-1:0] IDX_IMASK = 8'h11;

	// Bit positions in the sequence status register.
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_TRIG_BIT = 5;
	localparam int STAT_RES_BIT = 4;

	// Bit positions in the configuration register.
	localparam int CFG_FIFO_BIT = 0;
	localparam int CFG_FFC_BIT = 1;
	localparam int CFG_TLS_BIT = 2;
	localparam int CFG_TEN_BIT = 3;
	localparam int CFG_SCAN_BIT = 4;

	// Bit positions in the interrupt status and mask registers.
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_TRIG_BIT = 1;
	localparam int IRQ_RES_BIT = 2;

	// Values after reset.
	localparam logic [NCFG-1:0] CFG_RST = 5'h00;
	localparam logic [CCW-1:0] LEN_RST = 4'h1;
	localparam logic [CCW-1:0] CC_RST = 4'h0;
	localparam logic [NPOS-1:0] CMPE_RST = 10'h000;
	localparam logic [NPOS-1:0] COMPARE_DIRECTION_BIT_RST = 10'h000;
	localparam logic [NIRQ-1:0] IRQ_RST = 3'h0;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	// Sequencer states.
	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_RUN = 1'b1
	} adcsc_seq_t;

	// Result register write toward the result storage.
	typedef struct packed {
		logic vld;
		logic [CCW-1:0] idx;
		logic [RESW-1:0] data;
	} adcsc_wr_t;

	// Compare success toward the conversion done flags.
	typedef struct packed {
		logic vld;
		logic [CCW-1:0] idx;
	} adcsc_flag_t;

endpackage

// file: adcsc_cmp.sv
// Purpose: Magnitude compare of a new result against a stored value.
// Assumes: Both operands are unsigned and of the same width.
// Notes:   Purely combinational; the caller registers the outcome.
`timescale 1ns/100ps
module adcsc_cmp (
	input wire logic [adcsc_pkg::RESW-1:0] result,
	input wire logic [adcsc_pkg::RESW-1:0] stored,
	input wire logic higher_than,
	output logic success
);
	import adcsc_pkg::*;

	// Direction high tests above, low tests at or below.
	assign success = higher_than ? (result > stored) :
		(result <= stored); // R15
endmodule

// file: adcsc_top.sv
// Purpose: Sequence status, conversion counter and per-position
//          compare enables of a converter sequencer.
// Assumes: Converter events arrive on hclk; trigger pin is async.
// Notes:   Reads take one wait state, writes take none.
`timescale 1ns/100ps
module adcsc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic trigger_pin,
	input wire logic conv_done,
	input wire logic [adcsc_pkg::RESW-1:0] conv_data,
	input wire logic [adcsc_pkg::RESW-1:0] stored_value,
	input wire logic [adcsc_pkg::NPOS-1:0] ccf_flags,
	input wire logic result_read,
	output logic conv_run,
	output logic [adcsc_pkg::CCW-1:0] cc,
	output adcsc_pkg::adcsc_wr_t result_wr,
	output adcsc_pkg::adcsc_flag_t cmp_flag,
	output logic seq_abort,
	output logic irq
);
	import adcsc_pkg::*;

	////////////////////////////////////////////////////////////////
	// Register map by word index; the byte address is four times it.
	// Indices 0 to 3 hold no storage; a write there aborts a running
	// sequence and clears both overrun flags.
	// Index 4 is the configuration: FIFO mode, fast flag clear,
	// trigger level select, trigger enable and continuous scan.
	// Index 5 starts a sequence; its low nibble is the length, and a
	// length of zero means sixteen conversions.
	// Index 6 is the sequence status: done, trigger overrun, result
	// overrun and the read-only conversion counter.
	// Index 8 holds the compare enables and index 14 the directions.
	// Indices 16 and 17 are the interrupt status and its mask.
	// Unmapped indices read as zero and ignore writes.

	////////////////////////////////////////////////////////////////
	// Declarations.
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [IDXW-1:0] idx_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	logic [NCFG-1:0] cfg_ff;
	logic [CCW-1:0] len_ff;
	logic [NPOS-1:0] cmpe_ff;
	logic [NPOS-1:0] compare_direction_bit_ff;
	logic [NIRQ-1:0] istat_ff;
	logic [NIRQ-1:0] imask_ff;
	logic done_ff;
	logic trig_ovr_ff;
	logic res_ovr_ff;
	adcsc_seq_t seq_ff;
	logic run_ff;
	logic [CCW-1:0] num_ff;
	logic [CCW-1:0] cc_ff;
	logic trig_s1_ff;
	logic trig_s2_ff;
	logic trig_d_ff;
	adcsc_wr_t result_wr_ff;
	adcsc_flag_t cmp_flag_ff;
	logic seq_abort_ff;
	logic irq_ff;

	adcsc_seq_t nxt_seq;
	logic [CCW-1:0] nxt_num;
	logic [CCW-1:0] nxt_cc;
	logic nxt_done;
	logic nxt_trig_ovr;
	logic nxt_res_ovr;
	logic [NIRQ-1:0] nxt_istat;
	logic [NIRQ-1:0] nxt_imask;
	logic [31:0] nxt_rdata;

	////////////////////////////////////////////////////////////////
	// Bus decode of the address phase and the write data phase.
	wire acc = hsel & hready & htrans[1];
	wire wr_ctl = wr_pend_ff & (idx_ff <= IDX_CTL4);
	wire wr_cfg = wr_pend_ff & (idx_ff == IDX_CTL4);
	wire wr_start = wr_pend_ff & (idx_ff == IDX_START);
	wire wr_stat = wr_pend_ff & (idx_ff == IDX_STAT);
	wire wr_cmpe = wr_pend_ff & (idx_ff == IDX_CMPE);
	wire wr_compare_direction_bit = wr_pend_ff & (idx_ff == IDX_COMPARE_DIRECTION_BIT);
	wire wr_istat = wr_pend_ff & (idx_ff == IDX_ISTAT);
	wire wr_imask = wr_pend_ff & (idx_ff == IDX_IMASK);

	// Writes that abort the sequence and those that clear overruns.
	wire abort_req = wr_ctl | wr_cmpe | wr_compare_direction_bit; // R10
	wire ovr_clr = abort_req | wr_start; // R4

	// Configuration fields.
	wire fifo_mode = cfg_ff[CFG_FIFO_BIT];
	wire fast_flag_clear = cfg_ff[CFG_FFC_BIT];
	wire trigger_level_select = cfg_ff[CFG_TLS_BIT];
	wire trig_en = cfg_ff[CFG_TEN_BIT];
	wire scan_mode = cfg_ff[CFG_SCAN_BIT];

	////////////////////////////////////////////////////////////////
	// Trigger pin synchroniser and edge detector.
	// The pin is asynchronous, so two flops settle it before any logic
	// looks at it; the third flop keeps the settled level of the last
	// cycle for the rising-edge test.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_s1_ff <= 1'b0;
			trig_s2_ff <= 1'b0;
			trig_d_ff <= 1'b0;
		end else begin
			trig_s1_ff <= trigger_pin;
			trig_s2_ff <= trig_s1_ff;
			trig_d_ff <= trig_s2_ff;
		end
	end

	// Trigger starts an idle sequencer; in edge mode an edge while running overruns.
	wire trig_edge = trig_s2_ff & ~trig_d_ff;
	wire running = (seq_ff == SEQ_RUN);
	wire trig_act = trigger_level_select ? trig_s2_ff : trig_edge;
	wire trig_start = trig_en & trig_act & ~running;
	wire trig_ovr = trig_en & ~trigger_level_select & trig_edge &
		running; // R3
	wire start = (wr_start | trig_start) & ~abort_req;

	////////////////////////////////////////////////////////////////
	// Conversion bookkeeping for the position the counter names.
	// Positions ten and above have no compare enable and always store.
	wire conv_evt = conv_done & running & ~abort_req & ~wr_start;
	wire [15:0] cmpe_ext = {6'h0, cmpe_ff};
	wire [15:0] compare_direction_bit_ext = {6'h0, compare_direction_bit_ff};
	wire [15:0] ccf_ext = {6'h0, ccf_flags};
	wire cmp_on = cmpe_ext[cc_ff]; // R11
	wire cmp_ok;
	wire last = (num_ff == (len_ff - 4'h1));
	wire seq_end = conv_evt & last;
	wire restart = seq_end & scan_mode & ~trig_en;
	wire res_ovr = conv_evt & ~cmp_on & ccf_ext[cc_ff]; // R5

	// Compare of the new result against the value software loaded.
	adcsc_cmp u_cmp (
		.result(conv_data),
		.stored(stored_value), // R12
		.higher_than(compare_direction_bit_ext[cc_ff]),
		.success(cmp_ok)
	);

	// Sequencer state: abort beats start, start beats the end.
	// A continuous scan with the trigger off restarts at the end
	// instead of going idle; with the trigger on, each trigger
	// starts exactly one sequence.
	always_comb begin
		nxt_seq = seq_ff;
		case (seq_ff)
			SEQ_IDLE: begin
				if (start) begin
					nxt_seq = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (abort_req) begin
					nxt_seq = SEQ_IDLE; // R10
				end else if (seq_end && !restart && !start) begin
					nxt_seq = SEQ_IDLE;
				end
			end
			default: begin
				nxt_seq = SEQ_IDLE;
			end
		endcase
	end

	// Position within the sequence.
	assign nxt_num = (start | restart) ? CC_RST :
		conv_evt ? num_ff + 4'h1 : num_ff;

	// Counter zeroes at sequence edges unless FIFO mode, else wraps.
	wire cc_init = (start | seq_end | abort_req) & ~fifo_mode; // R8
	assign nxt_cc = cc_init ? CC_RST :
		conv_evt ? cc_ff + 4'h1 : cc_ff; // R9

	////////////////////////////////////////////////////////////////
	// Status flags; a set in the clearing cycle wins.
	// A conversion event never falls in the cycle of a start or an
	// abort write, so the counter and done flag see one cause each.
	wire done_clr = (wr_stat & hwdata[STAT_DONE_BIT]) | wr_start |
		(fast_flag_clear & result_read); // R2
	wire trig_clr = (wr_stat & hwdata[STAT_TRIG_BIT]) | ovr_clr; // R4
	wire res_clr = (wr_stat & hwdata[STAT_RES_BIT]) | ovr_clr; // R4
	assign nxt_done = seq_end | (done_ff & ~done_clr); // R1
	assign nxt_trig_ovr = trig_ovr | (trig_ovr_ff & ~trig_clr);
	assign nxt_res_ovr = res_ovr | (res_ovr_ff & ~res_clr);

	// Interrupt status is write-one-to-clear; mask is plain storage.
	wire [NIRQ-1:0] irq_set = {res_ovr, trig_ovr, seq_end};
	wire [NIRQ-1:0] irq_clr = wr_istat ? hwdata[NIRQ-1:0] : IRQ_RST;
	assign nxt_istat = irq_set | (istat_ff & ~irq_clr);
	assign nxt_imask = wr_imask ? hwdata[NIRQ-1:0] : imask_ff;

	////////////////////////////////////////////////////////////////
	// Read data selection; counter bits are the live counter.
	// The word is registered in the wait cycle, so the bus sees a
	// value that does not change during its data phase.
	wire [31:0] stat_rd = {24'h000000, done_ff, 1'b0, trig_ovr_ff,
		res_ovr_ff, cc_ff}; // R6
	wire [31:0] cfg_rd = {27'h0, cfg_ff};
	wire [31:0] len_rd = {28'h0000000, len_ff};
	wire [31:0] cmpe_rd = {22'h0, cmpe_ff};
	wire [31:0] compare_direction_bit_rd = {22'h0, compare_direction_bit_ff};
	wire [31:0] istat_rd = {29'h0, istat_ff};
	wire [31:0] imask_rd = {29'h0, imask_ff};
	assign nxt_rdata =
		(idx_ff == IDX_STAT) ? stat_rd :
		(idx_ff == IDX_CTL4) ? cfg_rd :
		(idx_ff == IDX_START) ? len_rd :
		(idx_ff == IDX_CMPE) ? cmpe_rd :
		(idx_ff == IDX_COMPARE_DIRECTION_BIT) ? compare_direction_bit_rd :
		(idx_ff == IDX_ISTAT) ? istat_rd :
		(idx_ff == IDX_IMASK) ? imask_rd : WORD_ZERO;

	////////////////////////////////////////////////////////////////
	// Bus phase tracking; a read stalls one cycle for fresh data.
	// Only the word index of the address phase is kept; the size is
	// not checked, as every register is one whole word.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			idx_ff <= 8'h00;
		end else begin
			wr_pend_ff <= acc & hwrite;
			rd_pend_ff <= acc & ~hwrite;
			if (acc) begin
				idx_ff <= haddr[IDXW+1:2];
			end
		end
	end

	// Ready, response and read data of the slave.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
			hrdata_ff <= WORD_ZERO;
		end else begin
			hreadyout_ff <= ~(acc & ~hwrite);
			if (rd_pend_ff) begin
				hrdata_ff <= nxt_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Software-written registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_ff <= CFG_RST;
			len_ff <= LEN_RST;
			cmpe_ff <= CMPE_RST; // R16
			compare_direction_bit_ff <= COMPARE_DIRECTION_BIT_RST;
			imask_ff <= IRQ_RST;
		end else begin
			if (wr_cfg) begin
				cfg_ff <= hwdata[NCFG-1:0];
			end
			if (wr_start) begin
				len_ff <= hwdata[CCW-1:0];
			end
			if (wr_cmpe) begin
				cmpe_ff <= hwdata[NPOS-1:0]; // R11
			end
			if (wr_compare_direction_bit) begin
				compare_direction_bit_ff <= hwdata[NPOS-1:0];
			end
			imask_ff <= nxt_imask;
		end
	end

	// Hardware state: sequencer, counters and flags.
	// The run output is registered from the next state, so it equals the sequencer state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_ff <= SEQ_IDLE;
			run_ff <= 1'b0;
			num_ff <= CC_RST;
			cc_ff <= CC_RST; // R16
			done_ff <= 1'b0;
			trig_ovr_ff <= 1'b0;
			res_ovr_ff <= 1'b0;
			istat_ff <= IRQ_RST;
		end else begin
			seq_ff <= nxt_seq;
			run_ff <= (nxt_seq == SEQ_RUN);
			num_ff <= nxt_num;
			cc_ff <= nxt_cc; // R7
			done_ff <= nxt_done;
			trig_ovr_ff <= nxt_trig_ovr;
			res_ovr_ff <= nxt_res_ovr;
			istat_ff <= nxt_istat;
		end
	end

	////////////////////////////////////////////////////////////////
	// Registered requests toward result storage and the flags.
	// The interrupt follows next-state status and mask so that it
	// rises in the same cycle as the flag that causes it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			result_wr_ff <= '0;
			cmp_flag_ff <= '0;
			seq_abort_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			result_wr_ff.vld <= conv_evt & ~cmp_on; // R14
			result_wr_ff.idx <= cc_ff;
			result_wr_ff.data <= conv_data;
			cmp_flag_ff.vld <= conv_evt & cmp_on & cmp_ok; // R13
			cmp_flag_ff.idx <= cc_ff;
			seq_abort_ff <= abort_req & running; // R10
			irq_ff <= |(nxt_istat & nxt_imask);
		end
	end

	// Output connections.
	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign conv_run = run_ff;
	assign cc = cc_ff;
	assign result_wr = result_wr_ff;
	assign cmp_flag = cmp_flag_ff;
	assign seq_abort = seq_abort_ff;
	assign irq = irq_ff;
endmodule

// file: adcsc_top_chk.sv
// Purpose: Concurrent checks on the ports of the status block.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/100ps
module adcsc_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic conv_done,
	input wire logic conv_run,
	input wire logic [adcsc_pkg::CCW-1:0] cc,
	input wire adcsc_pkg::adcsc_wr_t result_wr,
	input wire adcsc_pkg::adcsc_flag_t cmp_flag,
	input wire logic seq_abort
);
	import adcsc_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// A read is taken, then answered after exactly one wait state.
	sequence rd_req_s;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence rd_wait_s;
		!hreadyout ##1 hreadyout;
	endsequence
	////////////////////////////////////////////////////////////////////
	rd_wait_a: assert property (rd_req_s |=> rd_wait_s)
		else $error("read wait state wrong");
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("error response seen");
	wr_index_a: assert property (result_wr.vld |->
		$past(conv_done && conv_run) && result_wr.idx == $past(cc))
		else $error("result store index wrong");
	cmp_index_a: assert property (cmp_flag.vld |->
		!result_wr.vld && cmp_flag.idx == $past(cc) && cmp_flag.idx < NPOS)
		else $error("compare flag wrong");
	cc_step_a: assert property ((cc != $past(cc) && cc != CC_RST) |->
		$past(conv_done && conv_run) && cc == $past(cc) + 4'h1)
		else $error("counter step wrong");
	abort_stop_a: assert property (seq_abort |->
		!conv_run && $past(conv_run))
		else $error("abort pulse wrong");
	idle_quiet_a: assert property ((conv_done && !conv_run) |=>
		!result_wr.vld && !cmp_flag.vld)
		else $error("idle conversion taken");
	reset_zero_a: assert property ($rose(hresetn) |->
		cc == CC_RST && !conv_run && !seq_abort)
		else $error("state after reset wrong");
endmodule
bind adcsc_top adcsc_chk i_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .conv_done, .conv_run, .cc, .result_wr,
	.cmp_flag, .seq_abort);

// file: adcsc_bench.sv
// Purpose: Self-checking bench of the status and compare block.
// Assumes: Bench plays bus master and converter side.
// Notes:   Expectations follow from the register map constants.
`timescale 1ns/100ps
module adcsc_bench;
	import adcsc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, conv_done, result_read, trigger_pin, ab;
	logic hreadyout, hresp, conv_run, seq_abort, irq;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [RESW-1:0] conv_data, stored_value;
	logic [NPOS-1:0] ccf_flags;
	logic [CCW-1:0] cc;
	adcsc_wr_t result_wr, rw;
	adcsc_flag_t cmp_flag, cf;
	int errors = 0;
	int cmp_count = 0;
	// Clock and a latch of abort pulses.
	always #10 hclk = ~hclk;
	always @(posedge hclk) if (seq_abort === 1'b1) ab <= 1'b1;
	adcsc_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .trigger_pin, .conv_done, .conv_data, .stored_value,
		.ccf_flags, .result_read, .conv_run, .cc, .result_wr, .cmp_flag,
		.seq_abort, .irq);
	////////////////////////////////////////////////////////////////////
	// Comparison, bus and converter helpers.
	task chk(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] i, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, i, 2'h0};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [7:0] i, input logic [31:0] d);
		bus(1'b1, i, d);
	endtask
	task rc(input string n, input logic [7:0] i, input logic [31:0] e);
		bus(1'b0, i, 32'h0);
		chk(n, e, q);
	endtask
	task cv(input logic [9:0] d, s, f);
		conv_done <= 1'b1;
		conv_data <= d;
		stored_value <= s;
		ccf_flags <= f;
		@(posedge hclk);
		conv_done <= 1'b0;
		@(posedge hclk);
		rw = result_wr;
		cf = cmp_flag;
	endtask
	////////////////////////////////////////////////////////////////////
	// Scenarios.
	task t_idle;
		rc("status", IDX_STAT, 32'h0);
		rc("cmpe", IDX_CMPE, 32'h0);
		rc("unmapped", 8'h30, 32'h0);
		cv(10'h155, 10'h0, 10'h0);
		chk("idle store", 32'h0, rw.vld);
	endtask
	task t_seq;
		wr(IDX_IMASK, 32'h1);
		wr(IDX_START, 32'h3);
		for (int i = 0; i < 3; i++) begin
			cv(10'h100 + i[9:0], 10'h0, 10'h0);
			chk("store", {1'b1, i[3:0], 10'h100 + i[9:0]}, rw);
		end
		@(posedge hclk);
		chk("irq", 32'h1, irq);
		rc("status", IDX_STAT, 32'h80);
		wr(IDX_STAT, 32'h80);
		rc("status", IDX_STAT, 32'h0);
		wr(IDX_ISTAT, 32'h1);
		@(posedge hclk);
		chk("irq", 32'h0, irq);
	endtask
	task t_ovr;
		wr(IDX_CTL4, 32'h08);
		wr(IDX_START, 32'h2);
		cv(10'h011, 10'h0, 10'h001);
		trigger_pin <= 1'b1;
		repeat (4) @(posedge hclk);
		trigger_pin <= 1'b0;
		rc("status", IDX_STAT, 32'h31);
		ab = 1'b0;
		wr(IDX_CMPE, 32'h0);
		repeat (2) @(posedge hclk);
		chk("abort", 32'h1, ab);
		rc("status", IDX_STAT, 32'h0);
		wr(IDX_CTL4, 32'h0);
	endtask
	task t_cmp;
		wr(IDX_CMPE, 32'h3);
		wr(IDX_COMPARE_DIRECTION_BIT, 32'h1);
		rc("cmpe", IDX_CMPE, 32'h3);
		for (int k = 0; k < 2; k++) begin
			wr(IDX_START, 32'h2);
			cv(10'h200 - k[9:0], 10'h1FF, 10'h0);
			chk("higher", k == 0, cf.vld);
			chk("kept", 32'h0, rw.vld);
			cv(10'h1FF + k[9:0], 10'h1FF, 10'h0);
			chk("lower", k == 0, cf.vld);
		end
		wr(IDX_CMPE, 32'h0);
	endtask
	task t_fifo;
		wr(IDX_CTL4, 32'h1);
		wr(IDX_START, 32'h2);
		repeat (2) cv(10'h0, 10'h0, 10'h0);
		wr(IDX_STAT, 32'h0F);
		rc("status", IDX_STAT, 32'h82);
		wr(IDX_START, 32'h0);
		for (int i = 0; i < 16; i++) begin
			cv(10'h3A, 10'h0, 10'h0);
			chk("fifo index", (i + 2) & 15, rw.idx);
			chk("fifo counter", (i + 3) & 15, cc);
		end
		rc("status", IDX_STAT, 32'h82);
		wr(IDX_CTL4, 32'h0);
	endtask
	task t_fast;
		wr(IDX_IMASK, 32'h0);
		wr(IDX_CTL4, 32'h2);
		wr(IDX_START, 32'h1);
		cv(10'h0, 10'h0, 10'h0);
		@(posedge hclk);
		chk("masked irq", 32'h0, irq);
		rc("status", IDX_STAT, 32'h80);
		result_read <= 1'b1;
		@(posedge hclk);
		result_read <= 1'b0;
		rc("status", IDX_STAT, 32'h0);
	endtask
	task t_trig;
		wr(IDX_CTL4, 32'h0C);
		trigger_pin <= 1'b1;
		@(posedge hclk);
		trigger_pin <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("level start", 32'h1, conv_run);
		trigger_pin <= 1'b1;
		@(posedge hclk);
		trigger_pin <= 1'b0;
		repeat (3) @(posedge hclk);
		rc("status", IDX_STAT, 32'h0);
		cv(10'h0, 10'h0, 10'h0);
		chk("run end", 32'h0, conv_run);
		rc("status", IDX_STAT, 32'h80);
	endtask
	task t_scan;
		wr(IDX_CMPE, 32'h3FF);
		wr(IDX_CTL4, 32'h10);
		wr(IDX_START, 32'h1);
		cv(10'h0, 10'h0, 10'h0);
		chk("scan run", 32'h1, conv_run);
		wr(IDX_STAT, 32'h80);
		cv(10'h0, 10'h0, 10'h0);
		rc("status", IDX_STAT, 32'h80);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("reset run", 32'h0, conv_run);
		rc("status", IDX_STAT, 32'h0);
		rc("cmpe", IDX_CMPE, 32'h0);
	endtask
	task summarize;
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Main sequence, then a watchdog for hangs.
	initial begin
		{hresetn, hsel, hwrite, conv_done, result_read, trigger_pin} = 6'h0;
		{haddr, hwdata, htrans, ab} = 67'h0;
		{conv_data, stored_value, ccf_flags} = 30'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_idle;
		t_seq;
		t_ovr;
		t_cmp;
		t_fifo;
		t_fast;
		t_trig;
		t_scan;
		summarize;
	end
	initial begin
		#100000;
		errors++;
		summarize;
	end
endmodule
